// ===== rtl/vpm_consts.svh
`ifndef VPM_CONSTS_SVH
`define VPM_CONSTS_SVH
// exception levels
`define VPM_EL_USER 2'h0
`define VPM_EL_KERNEL 2'h1
`define VPM_EL_HYP 2'h2
`define VPM_EL_MON 2'h3
// partition register fields (user, kernel, hypervisor, monitor level)
`define VPM_PID_W 16
`define VPM_PMG_W 8
`define VPM_PID_D_LSB 0
`define VPM_PID_I_LSB 16
`define VPM_PMG_D_LSB 32
`define VPM_PMG_I_LSB 40
`define VPM_HYP_UTRAP_BIT 48
`define VPM_HYP_KTRAP_BIT 49
`define VPM_HYP_IDTRAP_BIT 58
// hypervisor map control fields
`define VPM_CTL_USER_EN_BIT 0
`define VPM_CTL_KERN_EN_BIT 1
`define VPM_CTL_LOCK_BIT 8
`define VPM_CTL_IDTRAP_BIT 31
// identification register fields
`define VPM_ID_PMAX_LSB 0
`define VPM_ID_VIRT_BIT 17
`define VPM_ID_VCNT_LSB 18
`define VPM_ID_VCNT_W 3
`define VPM_ID_HYP_REG_IDENT_TRAP_BIT 58
// map geometry
`define VPM_FIELDS_PER_REG 4
`define VPM_FIELD_W 16
`define VPM_MAX_MAPS 32
`define VPM_DEFAULT_VID 0
// reset values
`define VPM_RST_REG 64'h0
`define VPM_RST_PID 16'h0
`define VPM_DEFAULT_PID 16'h0
`endif

// ===== rtl/vpm_pkg.sv
package vpm_pkg;
   // system register selected by an access
   typedef enum logic [2:0] {
      VPM_REG_IDENT = 3'h0,
      VPM_REG_USER = 3'h1,
      VPM_REG_KERNEL = 3'h2,
      VPM_REG_HYP = 3'h3,
      VPM_REG_CTRL = 3'h4,
      VPM_REG_MAP = 3'h5,
      VPM_REG_VALID = 3'h6,
      VPM_REG_NONE = 3'h7
   } vpm_reg_t;
   typedef logic [1:0] vpm_el_t;
endpackage

// ===== rtl/vpm_xlate.sv
`timescale 1ns/100ps
`default_nettype none
`include "vpm_consts.svh"
module vpm_xlate #(
   parameter int NENT = 32,
   parameter int IW = 5,
   parameter int PHYS_W = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] virt_id,
   input wire logic [NENT*PHYS_W-1:0] map_flat,
   input wire logic [NENT-1:0] valid,
   input wire logic virt_en,
   output logic [15:0] phys_id
);
   localparam logic [15:0] VMAX = 16'(NENT - 1);
   logic [15:0] rep_id;
   logic [IW-1:0] idx;
   logic [PHYS_W-1:0] hit_entry;
   logic [PHYS_W-1:0] dflt_entry;

   // out-of-range ids are folded into range by clearing every bit that is clear in the max
   always_comb begin
      rep_id = (virt_id > VMAX) ? (virt_id & VMAX) : virt_id;
      idx = rep_id[IW-1:0];
      hit_entry = map_flat[int'(idx)*PHYS_W +: PHYS_W];
      dflt_entry = map_flat[`VPM_DEFAULT_VID*PHYS_W +: PHYS_W];
   end

   // valid entry, then default virtual entry, then default physical id
   always_comb begin
      if (!virt_en) begin
         phys_id = virt_id;
      end else if (valid[idx]) begin
         phys_id = 16'(hit_entry);
      end else if (valid[`VPM_DEFAULT_VID]) begin
         phys_id = 16'(dflt_entry);
      end else begin
         phys_id = `VPM_DEFAULT_PID;
      end
   end

   a_hit_entry: assert property (@(posedge clk) disable iff (!nrst)
      virt_en && valid[idx] |-> phys_id == 16'(hit_entry))
      else $error("valid entry not used");
   a_default_entry: assert property (@(posedge clk) disable iff (!nrst)
      virt_en && !valid[idx] && valid[0] |-> phys_id == 16'(map_flat[PHYS_W-1:0]))
      else $error("default virtual entry not used");
   a_default_phys: assert property (@(posedge clk) disable iff (!nrst)
      virt_en && !valid[idx] && !valid[0] |-> phys_id == 16'h0)
      else $error("default physical id not used");
   a_range_fold: assert property (@(posedge clk) disable iff (!nrst)
      virt_id > VMAX |-> 16'(idx) <= VMAX && 16'(idx) == (virt_id & VMAX))
      else $error("out-of-range id not folded");
endmodule
`default_nettype wire

// ===== rtl/vpm_mapper.sv
// How it works
// - map registers hold four 16-bit physical fields
// - largest virtual id is four times count plus three
// - count zero gives one register, max id 3
// - kernel map enable selects kernel id translation
// - user map enable translates user ids
// - host-at-hypervisor with trap-general disables user translation
// - lock makes user level use kernel register
// - locked user register feeds request ids only with host-at-hypervisor and trap-general
// - user register access unaffected by lock
// - valid indexed entry supplies physical id
// - invalid entry falls to default, then default physical
// - valid register holds four per map register
// - out-of-range ids folded into range
// - physical fields keep only implemented low bits
// - kernel ident access traps on either trap bit
// - hypervisor ident trap bit exists only if flagged
// - lower-level trap catches hypervisor register access
// - kernel and user register trap bits trap kernel access
// - hypervisor alias accesses never kernel-register trapped
// - lower-level trap catches all defined lower-level partition accesses
// - lower-level trap beats every hypervisor trap
// - default virtual entry is id zero, bit zero
// - translation exists only when virtualization present
`timescale 1ns/100ps
`default_nettype none
`include "vpm_consts.svh"
module vpm_mapper #(
   parameter logic [2:0] MAP_REG_COUNT = 3'h7,
   parameter int PHYS_W = 16,
   parameter logic [15:0] MAX_PHYS_ID = 16'hffff,
   parameter bit VIRT_PRESENT = 1'b1,
   parameter bit HYP_REG_IDENT_TRAP_PRESENT = 1'b1
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sr_valid,
   input wire logic sr_write,
   input wire vpm_pkg::vpm_reg_t sr_sel,
   input wire logic sr_alias,
   input wire logic [2:0] sr_map_idx,
   input wire vpm_pkg::vpm_el_t sr_el,
   input wire logic [63:0] sr_wdata,
   output logic sr_done_ff,
   output logic [63:0] sr_rdata_ff,
   output logic sr_trap_hyp_ff,
   output logic sr_trap_mon_ff,
   output logic sr_undef_ff,
   input wire vpm_pkg::vpm_el_t cur_el,
   input wire logic host_at_hypervisor,
   input wire logic trap_general,
   input wire logic lower_level_trap,
   input wire logic [63:0] monitor_level_partition_reg,
   output logic [15:0] out_data_partition_id_ff,
   output logic [15:0] out_instr_partition_id_ff,
   output logic [7:0] out_data_monitor_group_ff,
   output logic [7:0] out_instr_monitor_group_ff
);
   import vpm_pkg::*;

   localparam int NREG = int'(MAP_REG_COUNT) + 1;
   localparam int NENT = `VPM_FIELDS_PER_REG * NREG;
   localparam int IW = (NENT > 4) ? $clog2(NENT) : 2;
   localparam logic [15:0] MAX_VIRT_ID = 16'(4 * int'(MAP_REG_COUNT) + 3);

   logic [63:0] user_reg_ff;
   logic [63:0] kernel_reg_ff;
   logic [63:0] hyp_reg_ff;
   logic [63:0] ctrl_ff;
   logic [NENT-1:0] valid_ff;
   logic [NENT*PHYS_W-1:0] map_flat;
   vpm_reg_t eff_reg;
   logic undef;
   logic trap_mon;
   logic trap_hyp;
   logic wr_ok;
   logic [63:0] rdata;
   logic [63:0] ident_val;
   logic [63:0] ctx_reg;
   logic ctx_virt;
   logic [15:0] phys_d;
   logic [15:0] phys_i;

   // keep only the id and monitor group fields of a partition register
   function automatic logic [63:0] id_fields(input logic [63:0] w);
      logic [63:0] r;
      r = `VPM_RST_REG;
      r[`VPM_PID_D_LSB +: `VPM_PID_W] = w[`VPM_PID_D_LSB +: `VPM_PID_W];
      r[`VPM_PID_I_LSB +: `VPM_PID_W] = w[`VPM_PID_I_LSB +: `VPM_PID_W];
      r[`VPM_PMG_D_LSB +: `VPM_PMG_W] = w[`VPM_PMG_D_LSB +: `VPM_PMG_W];
      r[`VPM_PMG_I_LSB +: `VPM_PMG_W] = w[`VPM_PMG_I_LSB +: `VPM_PMG_W];
      return r;
   endfunction

   // identification register as read by software
   always_comb begin
      ident_val = `VPM_RST_REG;
      ident_val[`VPM_ID_PMAX_LSB +: 16] = MAX_PHYS_ID;
      ident_val[`VPM_ID_VIRT_BIT] = VIRT_PRESENT;
      ident_val[`VPM_ID_VCNT_LSB +: `VPM_ID_VCNT_W] = MAP_REG_COUNT;
      ident_val[`VPM_ID_HYP_REG_IDENT_TRAP_BIT] = HYP_REG_IDENT_TRAP_PRESENT;
   end

   // resolve the register really reached and whether the access is legal
   always_comb begin
      eff_reg = sr_sel;
      undef = 1'b0;
      if (sr_el == `VPM_EL_USER) begin
         undef = 1'b1;
      end else if (sr_el == `VPM_EL_KERNEL) begin
         undef = sr_alias || !(sr_sel inside {VPM_REG_IDENT, VPM_REG_USER, VPM_REG_KERNEL});
      end else if (sr_sel == VPM_REG_KERNEL && !sr_alias && sr_el == `VPM_EL_HYP && host_at_hypervisor) begin
         eff_reg = VPM_REG_HYP;
      end
      if (sr_alias && sr_sel != VPM_REG_KERNEL) begin
         undef = 1'b1;
      end
      if (!VIRT_PRESENT && sr_sel inside {VPM_REG_CTRL, VPM_REG_MAP, VPM_REG_VALID}) begin
         undef = 1'b1;
      end
      if (sr_sel == VPM_REG_MAP && sr_map_idx > MAP_REG_COUNT) begin
         undef = 1'b1;
      end
      if (sr_sel == VPM_REG_NONE) begin
         undef = 1'b1;
      end
   end

   // trap decision; lower-level trap is checked first and wins
   always_comb begin
      trap_mon = 1'b0;
      trap_hyp = 1'b0;
      if (!undef && sr_el != `VPM_EL_MON && lower_level_trap) begin
         trap_mon = 1'b1;
      end else if (!undef && sr_el == `VPM_EL_KERNEL) begin
         unique case (eff_reg)
            VPM_REG_IDENT: trap_hyp = (VIRT_PRESENT && ctrl_ff[`VPM_CTL_IDTRAP_BIT])
               || (HYP_REG_IDENT_TRAP_PRESENT && hyp_reg_ff[`VPM_HYP_IDTRAP_BIT]);
            VPM_REG_KERNEL: trap_hyp = hyp_reg_ff[`VPM_HYP_KTRAP_BIT];
            VPM_REG_USER: trap_hyp = hyp_reg_ff[`VPM_HYP_UTRAP_BIT];
            default: trap_hyp = 1'b0;
         endcase
      end
   end

   assign wr_ok = sr_valid && sr_write && !undef && !trap_mon && !trap_hyp;

   // read mux; trapped or undefined accesses return zero
   always_comb begin
      rdata = `VPM_RST_REG;
      unique case (eff_reg)
         VPM_REG_IDENT: rdata = ident_val;
         VPM_REG_USER: rdata = user_reg_ff;
         VPM_REG_KERNEL: rdata = kernel_reg_ff;
         VPM_REG_HYP: rdata = hyp_reg_ff;
         VPM_REG_CTRL: rdata = ctrl_ff;
         VPM_REG_VALID: rdata = 64'(valid_ff);
         VPM_REG_MAP: begin
            for (int f = 0; f < `VPM_FIELDS_PER_REG; f++) begin
               rdata[f*`VPM_FIELD_W +: `VPM_FIELD_W] =
                  16'(map_flat[(int'(sr_map_idx)*`VPM_FIELDS_PER_REG + f)*PHYS_W +: PHYS_W]);
            end
         end
         default: rdata = `VPM_RST_REG;
      endcase
      if (undef || trap_mon || trap_hyp) begin
         rdata = `VPM_RST_REG;
      end
   end

   // access answer, one cycle after the request
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sr_done_ff <= 1'b0;
         sr_rdata_ff <= `VPM_RST_REG;
         sr_trap_hyp_ff <= 1'b0;
         sr_trap_mon_ff <= 1'b0;
         sr_undef_ff <= 1'b0;
      end else begin
         sr_done_ff <= sr_valid;
         sr_rdata_ff <= (sr_valid && !sr_write) ? rdata : `VPM_RST_REG;
         sr_trap_hyp_ff <= sr_valid && trap_hyp;
         sr_trap_mon_ff <= sr_valid && trap_mon;
         sr_undef_ff <= sr_valid && undef;
      end
   end

   // user-level register; writes are plain whatever the lock says
   always_ff @(posedge clk) begin
      if (!nrst) begin
         user_reg_ff <= `VPM_RST_REG;
      end else if (wr_ok && eff_reg == VPM_REG_USER) begin
         user_reg_ff <= id_fields(sr_wdata);
      end
   end

   // kernel-level register, also reached through the alias
   always_ff @(posedge clk) begin
      if (!nrst) begin
         kernel_reg_ff <= `VPM_RST_REG;
      end else if (wr_ok && eff_reg == VPM_REG_KERNEL) begin
         kernel_reg_ff <= id_fields(sr_wdata);
      end
   end

   // hypervisor-level register with its trap controls
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hyp_reg_ff <= `VPM_RST_REG;
      end else if (wr_ok && eff_reg == VPM_REG_HYP) begin
         hyp_reg_ff <= id_fields(sr_wdata);
         hyp_reg_ff[`VPM_HYP_UTRAP_BIT] <= sr_wdata[`VPM_HYP_UTRAP_BIT];
         hyp_reg_ff[`VPM_HYP_KTRAP_BIT] <= sr_wdata[`VPM_HYP_KTRAP_BIT];
         hyp_reg_ff[`VPM_HYP_IDTRAP_BIT] <= HYP_REG_IDENT_TRAP_PRESENT && sr_wdata[`VPM_HYP_IDTRAP_BIT];
      end
   end

   // hypervisor map control enables and ident trap
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctrl_ff <= `VPM_RST_REG;
      end else if (wr_ok && eff_reg == VPM_REG_CTRL) begin
         ctrl_ff[`VPM_CTL_USER_EN_BIT] <= sr_wdata[`VPM_CTL_USER_EN_BIT];
         ctrl_ff[`VPM_CTL_KERN_EN_BIT] <= sr_wdata[`VPM_CTL_KERN_EN_BIT];
         ctrl_ff[`VPM_CTL_LOCK_BIT] <= sr_wdata[`VPM_CTL_LOCK_BIT];
         ctrl_ff[`VPM_CTL_IDTRAP_BIT] <= sr_wdata[`VPM_CTL_IDTRAP_BIT];
      end
   end

   // one valid bit per implemented virtual id
   always_ff @(posedge clk) begin
      if (!nrst) begin
         valid_ff <= '0;
      end else if (wr_ok && eff_reg == VPM_REG_VALID) begin
         valid_ff <= sr_wdata[NENT-1:0];
      end
   end

   // map entries: id v lives in register v/4, field v%4
   generate
      for (genvar i = 0; i < NENT; i++) begin : g_ent
         logic [PHYS_W-1:0] ent_ff;
         always_ff @(posedge clk) begin
            if (!nrst) begin
               ent_ff <= PHYS_W'(`VPM_RST_PID);
            end else if (wr_ok && eff_reg == VPM_REG_MAP && int'(sr_map_idx) == i / 4) begin
               ent_ff <= sr_wdata[(i % 4)*`VPM_FIELD_W +: PHYS_W];
            end
         end
         assign map_flat[i*PHYS_W +: PHYS_W] = ent_ff;
      end
   endgenerate

   // pick the id source and translation enable for the running level
   always_comb begin
      ctx_reg = hyp_reg_ff;
      ctx_virt = 1'b0;
      unique case (cur_el)
         `VPM_EL_USER: begin
            if (host_at_hypervisor && trap_general) begin
               ctx_reg = user_reg_ff;
               ctx_virt = 1'b0;
            end else if (ctrl_ff[`VPM_CTL_LOCK_BIT]) begin
               ctx_reg = kernel_reg_ff;
               ctx_virt = ctrl_ff[`VPM_CTL_KERN_EN_BIT];
            end else begin
               ctx_reg = user_reg_ff;
               ctx_virt = ctrl_ff[`VPM_CTL_USER_EN_BIT];
            end
         end
         `VPM_EL_KERNEL: begin
            ctx_reg = kernel_reg_ff;
            ctx_virt = ctrl_ff[`VPM_CTL_KERN_EN_BIT];
         end
         `VPM_EL_HYP: ctx_reg = hyp_reg_ff;
         `VPM_EL_MON: ctx_reg = monitor_level_partition_reg;
      endcase
      ctx_virt = ctx_virt && VIRT_PRESENT;
   end

   vpm_xlate #(.NENT(NENT), .IW(IW), .PHYS_W(PHYS_W)) u_xlate_d (
      .clk(clk),
      .nrst(nrst),
      .virt_id(ctx_reg[`VPM_PID_D_LSB +: `VPM_PID_W]),
      .map_flat(map_flat),
      .valid(valid_ff),
      .virt_en(ctx_virt),
      .phys_id(phys_d)
   );

   vpm_xlate #(.NENT(NENT), .IW(IW), .PHYS_W(PHYS_W)) u_xlate_i (
      .clk(clk),
      .nrst(nrst),
      .virt_id(ctx_reg[`VPM_PID_I_LSB +: `VPM_PID_W]),
      .map_flat(map_flat),
      .valid(valid_ff),
      .virt_en(ctx_virt),
      .phys_id(phys_i)
   );

   // request tags used by every load, store, fetch and walk
   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_data_partition_id_ff <= `VPM_RST_PID;
         out_instr_partition_id_ff <= `VPM_RST_PID;
         out_data_monitor_group_ff <= 8'h0;
         out_instr_monitor_group_ff <= 8'h0;
      end else begin
         out_data_partition_id_ff <= phys_d;
         out_instr_partition_id_ff <= phys_i;
         out_data_monitor_group_ff <= ctx_reg[`VPM_PMG_D_LSB +: `VPM_PMG_W];
         out_instr_monitor_group_ff <= ctx_reg[`VPM_PMG_I_LSB +: `VPM_PMG_W];
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   sequence s_valid_write;
      sr_valid && sr_write && sr_sel == VPM_REG_VALID && sr_el == `VPM_EL_HYP && !lower_level_trap;
   endsequence
   sequence s_valid_read;
      sr_valid && !sr_write && sr_sel == VPM_REG_VALID && sr_el == `VPM_EL_HYP && !lower_level_trap;
   endsequence

   a_valid_readback: assert property (
      s_valid_write ##1 !sr_valid ##1 s_valid_read |=> sr_rdata_ff == 64'($past(sr_wdata[NENT-1:0], 3)))
      else $error("valid bits readback wrong");
   a_lower_priority: assert property (
      sr_valid && lower_level_trap && sr_el != `VPM_EL_MON && !undef |=> sr_trap_mon_ff && !sr_trap_hyp_ff)
      else $error("lower-level trap lost priority");
   a_hyp_reg_trap: assert property (
      sr_valid && lower_level_trap && sr_el == `VPM_EL_HYP && sr_sel == VPM_REG_HYP && !sr_alias |=> sr_trap_mon_ff)
      else $error("hypervisor register not trapped");
   a_alias_no_trap: assert property (
      sr_valid && sr_el == `VPM_EL_HYP && sr_sel == VPM_REG_KERNEL && !lower_level_trap |=> !sr_trap_hyp_ff)
      else $error("hypervisor alias access trapped");
   a_kernel_trap: assert property (
      sr_valid && sr_el == `VPM_EL_KERNEL && sr_sel == VPM_REG_KERNEL && !sr_alias && !lower_level_trap
      && hyp_reg_ff[`VPM_HYP_KTRAP_BIT] |=> sr_trap_hyp_ff && sr_rdata_ff == 64'h0)
      else $error("kernel register access not trapped");
   a_ident_trap: assert property (
      sr_valid && sr_el == `VPM_EL_KERNEL && sr_sel == VPM_REG_IDENT && !sr_alias && !lower_level_trap
      && VIRT_PRESENT && ctrl_ff[`VPM_CTL_IDTRAP_BIT] |=> sr_trap_hyp_ff)
      else $error("ident access not trapped");
   a_kernel_phys: assert property (
      cur_el == `VPM_EL_KERNEL && !ctrl_ff[`VPM_CTL_KERN_EN_BIT]
      |=> out_data_partition_id_ff == $past(kernel_reg_ff[15:0]))
      else $error("kernel id not passed through");
   a_lock_user: assert property (
      cur_el == `VPM_EL_USER && ctrl_ff[`VPM_CTL_LOCK_BIT] && !(host_at_hypervisor && trap_general)
      && !ctrl_ff[`VPM_CTL_KERN_EN_BIT] |=> out_instr_partition_id_ff == $past(kernel_reg_ff[31:16]))
      else $error("locked user level not using kernel ids");
   a_host_app: assert property (
      cur_el == `VPM_EL_USER && host_at_hypervisor && trap_general
      |=> out_data_partition_id_ff == $past(user_reg_ff[15:0]))
      else $error("host application ids translated");
   a_answer_time: assert property (
      sr_valid |=> sr_done_ff ##1 !sr_done_ff || $past(sr_valid))
      else $error("access answer timing wrong");
endmodule
`default_nettype wire

// ===== dv/vpm_mem_sink.sv
`timescale 1ns/100ps
`default_nettype none
module vpm_mem_sink (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [15:0] data_partition_id,
   input wire logic [15:0] instr_partition_id,
   input wire logic [7:0] data_monitor_group,
   input wire logic [7:0] instr_monitor_group,
   output logic [47:0] tag_ff
);
   // every cycle is a request that carries the current tags
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tag_ff <= 48'h0;
      end else begin
         tag_ff <= {instr_monitor_group, data_monitor_group, instr_partition_id, data_partition_id};
      end
   end
endmodule
`default_nettype wire

// ===== dv/test_virtual_partition_id_mapper.sv
`timescale 1ns/100ps
`default_nettype none
module test_virtual_partition_id_mapper;
   import vpm_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sr_valid = 1'b0;
   logic sr_write = 1'b0;
   vpm_reg_t sr_sel = VPM_REG_NONE;
   logic sr_alias = 1'b0;
   logic [2:0] sr_map_idx = 3'h0;
   vpm_el_t sr_el = 2'h0;
   logic [63:0] sr_wdata = 64'h0;
   logic sr_done_ff, sr_trap_hyp_ff, sr_trap_mon_ff, sr_undef_ff;
   logic [63:0] sr_rdata_ff;
   vpm_el_t cur_el = 2'h0;
   logic hah = 1'b0;
   logic tg = 1'b0;
   logic llt = 1'b0;
   logic [63:0] mreg = 64'h0;
   logic [15:0] od, oi;
   logic [7:0] gd, gi;
   logic [47:0] sink_tag;
   logic [31:0] seed = 32'h0000_0984;
   logic [63:0] maps [8];
   logic [63:0] ctrl, ureg, kreg, hreg;
   logic [31:0] vmask;
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   localparam logic [3:0] OK = 4'h8;
   localparam logic [3:0] HYP = 4'hc;
   localparam logic [3:0] MON = 4'ha;
   localparam logic [3:0] UND = 4'h9;

   vpm_mapper i_dut (.clk(clk), .nrst(nrst), .sr_valid(sr_valid), .sr_write(sr_write), .sr_sel(sr_sel),
      .sr_alias(sr_alias), .sr_map_idx(sr_map_idx), .sr_el(sr_el), .sr_wdata(sr_wdata),
      .sr_done_ff(sr_done_ff), .sr_rdata_ff(sr_rdata_ff), .sr_trap_hyp_ff(sr_trap_hyp_ff),
      .sr_trap_mon_ff(sr_trap_mon_ff), .sr_undef_ff(sr_undef_ff), .cur_el(cur_el),
      .host_at_hypervisor(hah), .trap_general(tg), .lower_level_trap(llt),
      .monitor_level_partition_reg(mreg), .out_data_partition_id_ff(od), .out_instr_partition_id_ff(oi),
      .out_data_monitor_group_ff(gd), .out_instr_monitor_group_ff(gi));
   vpm_mem_sink i_sink (.clk(clk), .nrst(nrst), .data_partition_id(od), .instr_partition_id(oi),
      .data_monitor_group(gd), .instr_monitor_group(gi), .tag_ff(sink_tag));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         close_out();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // expected physical id for a virtual id
   function automatic logic [15:0] xl(input logic [15:0] v);
      logic [4:0] k;
      k = v[4:0];
      if (vmask[k]) return maps[k[4:2]][16*k[1:0] +: 16];
      if (vmask[0]) return maps[0][15:0];
      return 16'h0;
   endfunction

   // expected request tags at a level
   function automatic logic [47:0] tags(input vpm_el_t el);
      logic [63:0] r;
      logic en;
      r = kreg;
      en = ctrl[1];
      if (el == 2'h0) begin
         r = (ctrl[8] && !(hah && tg)) ? kreg : ureg;
         en = (hah && tg) ? 1'b0 : (ctrl[8] ? ctrl[1] : ctrl[0]);
      end else if (el[1]) begin
         r = el[0] ? mreg : hreg;
         en = 1'b0;
      end
      return {r[47:32], en ? xl(r[31:16]) : r[31:16], en ? xl(r[15:0]) : r[15:0]};
   endfunction

   task automatic cmp_word(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_flags(input logic [3:0] exp, input logic [3:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch flags expected %h seen %h", exp, got);
      end
   endtask

   // one register access: request for one cycle, answer checked in the next
   task automatic acc(input logic wr, input vpm_reg_t sel, input logic al, input logic [2:0] idx,
      input vpm_el_t el, input logic [63:0] wd, input logic [3:0] ef, input logic [63:0] ed);
      @(posedge clk);
      sr_valid <= 1'b1;
      sr_write <= wr;
      sr_sel <= sel;
      sr_alias <= al;
      sr_map_idx <= idx;
      sr_el <= el;
      sr_wdata <= wd;
      @(posedge clk);
      sr_valid <= 1'b0;
      sr_wdata <= ~wd;
      #1;
      cmp_flags(ef, {sr_done_ff, sr_trap_hyp_ff, sr_trap_mon_ff, sr_undef_ff});
      cmp_word("rdata", ed, sr_rdata_ff);
   endtask

   task automatic close_out();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      acc(1'b0, VPM_REG_CTRL, 1'b0, 3'h0, 2'h2, 64'h0, OK, 64'h0);
      acc(1'b0, VPM_REG_IDENT, 1'b0, 3'h0, 2'h2, 64'h0, OK, 64'h0400_0000_001e_ffff);
      for (int i = 0; i < 8; i++) begin
         maps[i] = {rnd(), rnd()};
         acc(1'b1, VPM_REG_MAP, 1'b0, i[2:0], 2'h2, maps[i], OK, 64'h0);
      end
      for (int i = 0; i < 8; i++) begin
         acc(1'b0, VPM_REG_MAP, 1'b0, i[2:0], 2'h2, 64'h0, OK, maps[i]);
      end
      for (int n = 0; n < 40; n++) begin
         vmask = (n == 0) ? 32'h0 : (n == 1) ? 32'h1 : (n == 2) ? 32'hffff_ffff : rnd();
         ctrl = {32'h0, rnd() & 32'h0000_0103};
         ureg = {rnd(), rnd()} & 64'h0000_ffff_ffff_ffff;
         kreg = {rnd(), rnd()} & 64'h0000_ffff_ffff_ffff;
         hreg = {rnd(), rnd()} & 64'h0000_ffff_ffff_ffff;
         acc(1'b1, VPM_REG_VALID, 1'b0, 3'h0, 2'h2, {32'h0, vmask}, OK, 64'h0);
         acc(1'b0, VPM_REG_VALID, 1'b0, 3'h0, 2'h2, 64'h0, OK, {32'h0, vmask});
         acc(1'b1, VPM_REG_CTRL, 1'b0, 3'h0, 2'h2, ctrl, OK, 64'h0);
         acc(1'b1, VPM_REG_USER, 1'b0, 3'h0, 2'h2, ureg, OK, 64'h0);
         acc(1'b1, VPM_REG_KERNEL, 1'b1, 3'h0, 2'h2, kreg, OK, 64'h0);
         acc(1'b1, VPM_REG_HYP, 1'b0, 3'h0, 2'h2, hreg, OK, 64'h0);
         @(posedge clk);
         cur_el <= (n < 8) ? 2'(n % 2) : 2'(rnd());
         hah <= (n > 3) ? 1'(rnd()) : 1'b0;
         tg <= (n > 3) ? 1'(rnd()) : 1'b0;
         mreg <= {rnd(), rnd()};
         repeat (2) @(posedge clk);
         #1;
         cmp_word("tags", {16'h0, tags(cur_el)}, {16'h0, gi, gd, oi, od});
         @(posedge clk);
         #1;
         cmp_word("sink", {16'h0, tags(cur_el)}, {16'h0, sink_tag});
      end
      // traps and refusals
      acc(1'b1, VPM_REG_CTRL, 1'b0, 3'h0, 2'h2, 64'h8000_0100, OK, 64'h0);
      acc(1'b0, VPM_REG_IDENT, 1'b0, 3'h0, 2'h1, 64'h0, HYP, 64'h0);
      acc(1'b1, VPM_REG_USER, 1'b0, 3'h0, 2'h1, ureg, OK, 64'h0);
      acc(1'b0, VPM_REG_USER, 1'b0, 3'h0, 2'h1, 64'h0, OK, ureg);
      acc(1'b1, VPM_REG_CTRL, 1'b0, 3'h0, 2'h2, 64'h0, OK, 64'h0);
      hreg = hreg | 64'h0403_0000_0000_0000;
      acc(1'b1, VPM_REG_HYP, 1'b0, 3'h0, 2'h2, hreg, OK, 64'h0);
      acc(1'b0, VPM_REG_IDENT, 1'b0, 3'h0, 2'h1, 64'h0, HYP, 64'h0);
      acc(1'b0, VPM_REG_USER, 1'b0, 3'h0, 2'h1, 64'h0, HYP, 64'h0);
      acc(1'b1, VPM_REG_KERNEL, 1'b0, 3'h0, 2'h1, 64'h5, HYP, 64'h0);
      acc(1'b0, VPM_REG_KERNEL, 1'b1, 3'h0, 2'h2, 64'h0, OK, kreg);
      @(posedge clk);
      hah <= 1'b1;
      acc(1'b0, VPM_REG_KERNEL, 1'b0, 3'h0, 2'h2, 64'h0, OK, hreg);
      acc(1'b0, VPM_REG_USER, 1'b0, 3'h0, 2'h0, 64'h0, UND, 64'h0);
      acc(1'b0, VPM_REG_CTRL, 1'b0, 3'h0, 2'h1, 64'h0, UND, 64'h0);
      acc(1'b0, VPM_REG_KERNEL, 1'b1, 3'h0, 2'h1, 64'h0, UND, 64'h0);
      @(posedge clk);
      llt <= 1'b1;
      acc(1'b0, VPM_REG_KERNEL, 1'b0, 3'h0, 2'h1, 64'h0, MON, 64'h0);
      acc(1'b0, VPM_REG_IDENT, 1'b0, 3'h0, 2'h1, 64'h0, MON, 64'h0);
      acc(1'b1, VPM_REG_HYP, 1'b0, 3'h0, 2'h2, 64'h0, MON, 64'h0);
      acc(1'b0, VPM_REG_MAP, 1'b0, 3'h3, 2'h2, 64'h0, MON, 64'h0);
      acc(1'b0, VPM_REG_HYP, 1'b0, 3'h0, 2'h3, 64'h0, OK, hreg);
      close_out();
   end
endmodule
`default_nettype wire
